// file: design/chip_select_map.vh
`ifndef CHIP_SELECT_MAP_VH
`define CHIP_SELECT_MAP_VH

// Number of chip-select windows
`define CS_NUM_WINDOWS 8
// Width of the base and mask fields (address bits 31..16)
`define CS_BASE_W 16
// Lowest decoded address bit, 64 Kbyte granule
`define CS_BASE_LSB 16
// Width of the wait-state count
`define CS_WAIT_W 4

// Port width encodings, same as the boot strap pins
`define CS_PW_32 2'h0
`define CS_PW_8 2'h1
`define CS_PW_16 2'h2

// Transfer size encodings
`define CS_SZ_LONG 2'h0
`define CS_SZ_BYTE 2'h1
`define CS_SZ_WORD 2'h2
`define CS_SZ_LINE 2'h3

// Boot strap bit positions in the synchronised strap vector
`define CS_STRAP_ACK 3
`define CS_STRAP_PW_HI 2
`define CS_STRAP_PW_LO 1
`define CS_STRAP_LANE 0

// Reset values of the boot configuration
`define CS_RST_PW 2'h0
`define CS_RST_ACK 1'h0
`define CS_RST_LANE 1'h1
// Wait states used by the boot window with internal acknowledge
`define CS_BOOT_WAIT 4'hF

// Lane strobe patterns, bit n drives lane n, low asserts
`define CS_LANES_NONE 4'hF
`define CS_LANES_L0 4'hE
`define CS_LANES_L1 4'hD
`define CS_LANES_L01 4'hC
`define CS_LANES_L23 4'h3
`define CS_LANES_ALL 4'h0

`endif

// file: design/lane_strobe_decode.v
`timescale 1ns/1ps
`include "chip_select_map.vh"

// Combinational lane strobe pattern from size, low address and width
module lane_strobe_decode (
  input wire [1:0] i_size,
  input wire [1:0] i_addr_lo,
  input wire [1:0] i_port_width,
  output reg [3:0] o_lanes_n
);

  // Width code 1x means a 16-bit port
  wire is_16;
  wire is_8;
  assign is_16 = i_port_width[1];
  assign is_8 = (i_port_width == `CS_PW_8);

  // Pattern table; lane 0 carries data bits 31..24, lane 3 bits 7..0
  always @* begin
    o_lanes_n = `CS_LANES_NONE;
    case (i_size)
      `CS_SZ_BYTE: begin
        if (is_8) begin
          o_lanes_n = `CS_LANES_L0;
        end else if (is_16) begin
          o_lanes_n = i_addr_lo[0] ? `CS_LANES_L1 : `CS_LANES_L0;
        end else begin
          case (i_addr_lo)
            2'h0: o_lanes_n = 4'hE;
            2'h1: o_lanes_n = 4'hD;
            2'h2: o_lanes_n = 4'hB;
            default: o_lanes_n = 4'h7;
          endcase
        end
      end
      `CS_SZ_WORD: begin
        if (is_8) begin
          o_lanes_n = `CS_LANES_L0;
        end else if (is_16) begin
          o_lanes_n = `CS_LANES_L01;
        end else begin
          o_lanes_n = i_addr_lo[1] ? `CS_LANES_L23 : `CS_LANES_L01;
        end
      end
      default: begin
        // Longword and line transfers
        if (is_8) begin
          o_lanes_n = `CS_LANES_L0;
        end else if (is_16) begin
          o_lanes_n = `CS_LANES_L01;
        end else begin
          o_lanes_n = `CS_LANES_ALL;
        end
      end
    endcase
  end

endmodule

// file: design/chip_select_byte_lane_decode.v
// Operation
// - Eight independent active-low programmable chip selects.
// - Masked windows from 64 Kbyte to 4 Gbyte.
// - Per-select base, mask, width, burst, wait, termination.
// - Decode external master cycles like processor cycles.
// - Per-select wait count and width applied each cycle.
// - After reset only boot select active, global.
// - Boot width, termination, lane mode latched at reset.
// - Output strobe changes on falling bus clock, or negates while reset input held.
// - Output strobe only on matching read cycles.
// - Output strobe is read enable of window.
// - Lane mode bit picks byte or write enables.
// - Lanes from size, low address, width, lane mode.
// - Lane 0 is bits 31..24, low selects.
// - Byte transfer lane choice per port width.
// - Word transfer lane choice per port width.
// - Longword and line lane choice per width.
// - No match: external, burst-inhibited, 32-bit cycle.
// - Multiple matches: all drive, external 32-bit inhibited.
// - Boot select global until its valid bit set.
// - Strap ack gives 15 waits; width code 00/01/1x.
`timescale 1ns/1ps
`include "chip_select_map.vh"

module chip_select_byte_lane_decode #(
  parameter NUM_WIN = `CS_NUM_WINDOWS,
  parameter BASE_W = `CS_BASE_W,
  parameter WAIT_W = `CS_WAIT_W
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_bus_clk,
  input wire i_reset_input_n,
  input wire [3:0] i_boot_strap_pins,
  input wire i_boot_window_valid_bit,
  input wire [NUM_WIN-1:0] i_win_valid,
  input wire [NUM_WIN*BASE_W-1:0] i_win_base,
  input wire [NUM_WIN*BASE_W-1:0] i_win_mask,
  input wire [NUM_WIN*2-1:0] i_win_port_width,
  input wire [NUM_WIN-1:0] i_win_read_burst,
  input wire [NUM_WIN-1:0] i_win_write_burst,
  input wire [NUM_WIN*WAIT_W-1:0] i_win_wait_states,
  input wire [NUM_WIN-1:0] i_win_internal_ack_enable,
  input wire [NUM_WIN-1:0] i_win_lane_mode_bit,
  input wire i_cycle_valid,
  input wire [31:0] i_cycle_addr,
  input wire [1:0] i_cycle_size,
  input wire i_cycle_read,
  output wire o_boot_window_select_n,
  output wire [NUM_WIN-1:1] o_chip_select_n,
  output wire o_output_strobe_n,
  output wire [3:0] o_lane_select_n,
  output wire [1:0] o_port_width,
  output wire [WAIT_W-1:0] o_wait_states,
  output wire o_internal_ack_enable,
  output wire o_burst_inhibit,
  output wire o_multi_match,
  output wire o_cycle_ack,
  output wire o_boot_global
);

  // Pin synchronisers: bus clock, reset input, strap pins
  reg bus_clk_s1_q;
  reg bus_clk_s2_q;
  reg bus_clk_s3_q;
  reg reset_input_n_s1_q;
  reg reset_input_n_s2_q;
  reg reset_input_n_s3_q;
  reg [3:0] strap_s1_q;
  reg [3:0] strap_s2_q;

  // Boot configuration captured at reset input release
  reg [1:0] strap_pw_q;
  reg strap_ack_q;
  reg strap_lane_q;
  // Sticky: boot window has been made valid by software
  reg boot_valid_seen_q;
  // Status pin flop: high while the boot window decodes everything
  reg boot_global_q;

  // Registered pin outputs
  reg [NUM_WIN-1:0] cs_n_q;
  reg oe_n_q;
  reg [3:0] lanes_n_q;
  reg [1:0] pw_q;
  reg [WAIT_W-1:0] wait_q;
  reg iack_q;
  reg binh_q;
  reg multi_q;
  reg ack_q;

  // Wait-state sequencing for internal acknowledge
  reg cyc_active_q;
  reg ack_done_q;
  reg [WAIT_W-1:0] wait_cnt_q;

  // Falling edge of the synchronised bus clock, one ref-clock pulse
  wire bus_fall;
  // Release edge of the synchronised reset input
  wire reset_input_n_rise;
  // Reset input still held low by the board
  wire in_reset;
  assign bus_fall = bus_clk_s3_q & ~bus_clk_s2_q;
  assign reset_input_n_rise = reset_input_n_s2_q & ~reset_input_n_s3_q;
  assign in_reset = ~reset_input_n_s2_q;

  // Two-flop synchronisers and edge history
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_clk_s1_q <= 1'h0;
      bus_clk_s2_q <= 1'h0;
      bus_clk_s3_q <= 1'h0;
      reset_input_n_s1_q <= 1'h0;
      reset_input_n_s2_q <= 1'h0;
      reset_input_n_s3_q <= 1'h0;
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
    end else begin
      bus_clk_s1_q <= i_bus_clk;
      bus_clk_s2_q <= bus_clk_s1_q;
      bus_clk_s3_q <= bus_clk_s2_q;
      reset_input_n_s1_q <= i_reset_input_n;
      reset_input_n_s2_q <= reset_input_n_s1_q;
      reset_input_n_s3_q <= reset_input_n_s2_q;
      strap_s1_q <= i_boot_strap_pins;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Strap capture and boot valid tracking
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_pw_q <= `CS_RST_PW;
      strap_ack_q <= `CS_RST_ACK;
      strap_lane_q <= `CS_RST_LANE;
      boot_valid_seen_q <= 1'h0;
      boot_global_q <= 1'h1;
    end else begin
      if (reset_input_n_rise) begin
        // Board holds the levels as reset input negates
        strap_ack_q <= strap_s2_q[`CS_STRAP_ACK];
        strap_pw_q <= strap_s2_q[`CS_STRAP_PW_HI:`CS_STRAP_PW_LO];
        strap_lane_q <= strap_s2_q[`CS_STRAP_LANE];
      end
      if (in_reset) begin
        // Global boot select restored only by reset
        boot_valid_seen_q <= 1'h0;
        boot_global_q <= 1'h1;
      end else if (i_boot_window_valid_bit) begin
        boot_valid_seen_q <= 1'h1;
        // Boot window now follows its programmed decode
        boot_global_q <= 1'h0;
      end
    end
  end

  // Per-window address match, mask bit set ignores that address bit
  wire [NUM_WIN-1:0] hit;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi = gi + 1) begin : g_win
      wire [BASE_W-1:0] base_w;
      wire [BASE_W-1:0] mask_w;
      wire addr_eq;
      assign base_w = i_win_base[gi*BASE_W +: BASE_W];
      assign mask_w = i_win_mask[gi*BASE_W +: BASE_W];
      // Masked compare of address bits 31..16
      assign addr_eq = (((i_cycle_addr[31:`CS_BASE_LSB] ^ base_w) & ~mask_w)
                        == {BASE_W{1'b0}});
      if (gi == 0) begin : g_boot
        // Boot select decodes every access until made valid
        assign hit[gi] = ~boot_valid_seen_q | addr_eq;
      end else begin : g_other
        // Others unusable until boot select valid
        assign hit[gi] = boot_valid_seen_q & i_win_valid[gi] & addr_eq;
      end
    end
  endgenerate

  // Effective boot window attributes: straps until valid, then programmed
  wire [1:0] boot_pw;
  wire boot_ack;
  wire boot_lane;
  wire [WAIT_W-1:0] boot_wait;
  wire boot_rburst;
  wire boot_wburst;
  assign boot_pw = boot_valid_seen_q ? i_win_port_width[1:0] : strap_pw_q;
  assign boot_ack = boot_valid_seen_q ? i_win_internal_ack_enable[0] : strap_ack_q;
  assign boot_lane = boot_valid_seen_q ? i_win_lane_mode_bit[0] : strap_lane_q;
  assign boot_wait = boot_valid_seen_q ? i_win_wait_states[WAIT_W-1:0] :
                     (strap_ack_q ? `CS_BOOT_WAIT : {WAIT_W{1'b0}});
  assign boot_rburst = boot_valid_seen_q & i_win_read_burst[0];
  assign boot_wburst = boot_valid_seen_q & i_win_write_burst[0];

  // Match count; hit minus one clears the lowest set bit
  wire any_hit;
  wire multi_hit;
  wire [NUM_WIN-1:0] hit_less;
  assign hit_less = hit - {{(NUM_WIN-1){1'b0}}, 1'b1};
  assign any_hit = |hit;
  assign multi_hit = |(hit & hit_less);

  // Attributes of the single matching window, OR-selected
  reg [1:0] sel_pw;
  reg [WAIT_W-1:0] sel_wait;
  reg sel_ack;
  reg sel_lane;
  reg sel_burst;
  integer k;
  always @* begin
    sel_pw = {2{hit[0]}} & boot_pw;
    sel_wait = {WAIT_W{hit[0]}} & boot_wait;
    sel_ack = hit[0] & boot_ack;
    sel_lane = hit[0] & boot_lane;
    sel_burst = hit[0] & (i_cycle_read ? boot_rburst : boot_wburst);
    for (k = 1; k < NUM_WIN; k = k + 1) begin
      sel_pw = sel_pw | ({2{hit[k]}} & i_win_port_width[k*2 +: 2]);
      sel_wait = sel_wait | ({WAIT_W{hit[k]}} & i_win_wait_states[k*WAIT_W +: WAIT_W]);
      sel_ack = sel_ack | (hit[k] & i_win_internal_ack_enable[k]);
      sel_lane = sel_lane | (hit[k] & i_win_lane_mode_bit[k]);
      sel_burst = sel_burst | (hit[k] & (i_cycle_read ? i_win_read_burst[k] :
                                         i_win_write_burst[k]));
    end
  end

  // Cycle attributes: single match uses window, else default external
  reg single;
  reg [1:0] cyc_pw;
  reg [WAIT_W-1:0] cyc_wait;
  reg cyc_ack;
  reg cyc_lane;
  reg cyc_binh;
  always @* begin
    single = any_hit & ~multi_hit;
    if (single) begin
      cyc_pw = sel_pw;
      cyc_wait = sel_wait;
      cyc_ack = sel_ack;
      cyc_lane = sel_lane;
      cyc_binh = ~sel_burst;
    end else begin
      // None or several matching: 32-bit, external, burst-inhibited
      cyc_pw = `CS_PW_32;
      cyc_wait = {WAIT_W{1'b0}};
      cyc_ack = 1'h0;
      cyc_lane = 1'h1;
      cyc_binh = 1'h1;
    end
  end

  // Lane pattern for this cycle
  wire [3:0] lanes_raw_n;
  lane_strobe_decode u_lanes (
    .i_size(i_cycle_size),
    .i_addr_lo(i_cycle_addr[1:0]),
    .i_port_width(cyc_pw),
    .o_lanes_n(lanes_raw_n)
  );

  // Lanes gated: write-enable mode blocks reads
  wire lanes_on;
  assign lanes_on = i_cycle_valid & (cyc_lane | ~i_cycle_read);

  // Pin strobes, updated on the bus clock falling edge and negated while reset input held
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_n_q <= {NUM_WIN{1'b1}};
      oe_n_q <= 1'h1;
      lanes_n_q <= `CS_LANES_NONE;
      pw_q <= `CS_PW_32;
      wait_q <= {WAIT_W{1'b0}};
      iack_q <= 1'h0;
      binh_q <= 1'h1;
      multi_q <= 1'h0;
    end else if (in_reset) begin
      // Board reset input held: selects, output strobe, lanes and multi-match negated
      cs_n_q <= {NUM_WIN{1'b1}};
      oe_n_q <= 1'h1;
      lanes_n_q <= `CS_LANES_NONE;
      multi_q <= 1'h0;
    end else if (bus_fall) begin
      // Any initiator: decode does not look at who drives the cycle
      cs_n_q <= ~(hit & {NUM_WIN{i_cycle_valid}});
      oe_n_q <= ~(i_cycle_valid & i_cycle_read & any_hit);
      lanes_n_q <= lanes_on ? lanes_raw_n : `CS_LANES_NONE;
      pw_q <= cyc_pw;
      wait_q <= cyc_wait;
      iack_q <= cyc_ack;
      binh_q <= cyc_binh;
      multi_q <= i_cycle_valid & multi_hit;
    end
  end

  // Wait-state counter; internal ack after the counted bus edges
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_active_q <= 1'h0;
      ack_done_q <= 1'h0;
      wait_cnt_q <= {WAIT_W{1'b0}};
      ack_q <= 1'h0;
    end else begin
      ack_q <= 1'h0;
      if (in_reset) begin
        cyc_active_q <= 1'h0;
        ack_done_q <= 1'h0;
      end else if (bus_fall) begin
        if (!i_cycle_valid) begin
          // Cycle over, rearm
          cyc_active_q <= 1'h0;
          ack_done_q <= 1'h0;
        end else if (!cyc_active_q) begin
          // First edge of a cycle loads its wait count
          cyc_active_q <= 1'h1;
          wait_cnt_q <= cyc_wait;
        end else if (wait_cnt_q != {WAIT_W{1'b0}}) begin
          wait_cnt_q <= wait_cnt_q - {{(WAIT_W-1){1'b0}}, 1'b1};
        end else if (iack_q && !ack_done_q) begin
          // Internal termination, one pulse per cycle
          ack_q <= 1'h1;
          ack_done_q <= 1'h1;
        end
      end
    end
  end

  // Outputs straight from flip-flops
  assign o_boot_window_select_n = cs_n_q[0];
  assign o_chip_select_n = cs_n_q[NUM_WIN-1:1];
  assign o_output_strobe_n = oe_n_q;
  assign o_lane_select_n = lanes_n_q;
  assign o_port_width = pw_q;
  assign o_wait_states = wait_q;
  assign o_internal_ack_enable = iack_q;
  assign o_burst_inhibit = binh_q;
  assign o_multi_match = multi_q;
  assign o_cycle_ack = ack_q;
  // Status pin from its own flop rather than through an inverter
  assign o_boot_global = boot_global_q;

endmodule

// file: testbench/cs_decode_monitor.sv
`timescale 1ns/1ps
// Watches decoder pins: strobe timing and cycle attributes
module cs_decode_monitor #(
  parameter NUM_WIN = 8,
  parameter WAIT_W = 4
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_bus_clk,
  input wire i_cycle_read,
  input wire o_boot_window_select_n,
  input wire [NUM_WIN-1:1] o_chip_select_n,
  input wire o_output_strobe_n,
  input wire [3:0] o_lane_select_n,
  input wire [1:0] o_port_width,
  input wire [WAIT_W-1:0] o_wait_states,
  input wire o_internal_ack_enable,
  input wire o_burst_inhibit,
  input wire o_multi_match,
  input wire o_cycle_ack,
  input wire o_boot_global
);
  reg [2:0] sync_q; // Own copy of the bus clock synchroniser
  wire fall_seen = sync_q[2] & ~sync_q[1];
  wire [NUM_WIN-1:0] sel_n = {o_chip_select_n, o_boot_window_select_n};
  wire no_sel = &sel_n; // No select driven
  wire lanes_on = o_lane_select_n != 4'hF; // Some lane driven
  // Shift the bus clock pin through three flops
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], i_bus_clk};
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_strobe_on_fall: assert property (
    $changed({o_output_strobe_n, o_lane_select_n}) |-> $past(fall_seen))
    else $error("strobe moved away from a bus clock fall");
  a_select_on_fall: assert property (
    $changed(sel_n) |-> $past(fall_seen))
    else $error("select moved away from a bus clock fall");
  a_strobe_read_only: assert property (
    $fell(o_output_strobe_n) |-> $past(i_cycle_read) && !no_sel)
    else $error("read strobe without read or match");
  a_no_match_ext: assert property (
    no_sel && lanes_on |-> o_port_width == 2'h0 && !o_internal_ack_enable && o_burst_inhibit)
    else $error("unmatched cycle not external 32-bit");
  a_multi_match_ext: assert property (
    o_multi_match && !no_sel |-> $countones(~sel_n) > 1 && o_port_width == 2'h0
      && !o_internal_ack_enable && o_burst_inhibit)
    else $error("multiple match handled wrongly");
  a_byte_port_lane: assert property (
    o_port_width == 2'h1 && lanes_on |-> o_lane_select_n == 4'hE)
    else $error("8-bit port drove a lane other than 0");
  a_half_port_lane: assert property (
    o_port_width[1] && lanes_on |-> o_lane_select_n inside {4'hE, 4'hD, 4'hC})
    else $error("16-bit port drove lane 2 or 3");
  a_boot_wait_count: assert property (
    o_boot_global && o_internal_ack_enable && !o_boot_window_select_n |-> o_wait_states == 4'hF)
    else $error("boot internal ack without 15 waits");
  a_global_alone: assert property (
    o_boot_global |-> &o_chip_select_n)
    else $error("other select used while boot is global");
  a_ack_single: assert property (
    o_cycle_ack |-> o_internal_ack_enable ##1 !o_cycle_ack)
    else $error("ack longer than a cycle or not internal");
  a_ack_not_early: assert property (
    $fell(o_boot_window_select_n) && o_internal_ack_enable && o_wait_states == 4'hF
      |-> !o_cycle_ack [*8])
    else $error("ack came before the wait states ran");
  c_read_strobe: cover property ($fell(o_output_strobe_n));
  c_multi_match: cover property (o_multi_match && !no_sel);
  c_ack_pulse: cover property (o_cycle_ack);
endmodule

bind chip_select_byte_lane_decode cs_decode_monitor #(
  .NUM_WIN(NUM_WIN),
  .WAIT_W(WAIT_W)
) cs_decode_monitor_inst (.i_ref_clk, .i_rst_n, .i_bus_clk, .i_cycle_read,
  .o_boot_window_select_n, .o_chip_select_n, .o_output_strobe_n, .o_lane_select_n,
  .o_port_width, .o_wait_states, .o_internal_ack_enable, .o_burst_inhibit,
  .o_multi_match, .o_cycle_ack, .o_boot_global);

// file: testbench/board_strap_model.sv
`timescale 1ns/1ps
// Board side: strap levels on data pins, then live bus data
module board_strap_model (
  input wire i_ref_clk,
  input wire i_reset_input_n,
  input wire [3:0] i_cfg,
  output reg [3:0] o_pins
);
  reg [3:0] hold_q = 4'h0; // Cycles since reset input release
  initial o_pins = 4'h0;
  // Hold straps around release, then toggle like a busy bus
  always @(posedge i_ref_clk) begin
    if (!i_reset_input_n) begin
      hold_q <= 4'h0;
      o_pins <= i_cfg;
    end else if (hold_q != 4'h8) begin
      hold_q <= hold_q + 4'h1;
    end else begin
      o_pins <= ~o_pins; // Hold time over, value no longer valid
    end
  end
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam [79:0] HI_TAB = 80'h01000002000300010000; // Upper address per region
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg bus_clk = 1'b0;
  reg rin_n = 1'b0; // Board reset input
  reg vbit = 1'b0; // Boot window valid
  reg [127:0] base = {64'h0, 16'h0002, 16'h0002, 16'h0001, 16'h0000};
  reg [127:0] mask = {64'h0, 16'h0001, 48'h0};
  reg [7:0] rburst = 8'h0, wburst = 8'h0, iack = 8'h0;
  reg [31:0] waits = 32'h0;
  reg cvalid = 1'b0;
  reg [31:0] addr = 32'h0;
  reg [1:0] size = 2'h0;
  reg rd = 1'b0;
  wire [3:0] pins;
  wire cs0_n, oe_n, ack, bglob;
  wire [7:1] cs_n;
  wire [3:0] lanes_n;
  wire [1:0] pw; // Cycle attributes
  wire [3:0] wst;
  wire iak, binh, multi;
  integer bad_count = 0, total_checks = 0, cyc_cnt = 0, acks = 0, i;
  reg [12:0] exq[$]; // Expected {selects, strobe, lanes}
  board_strap_model board_strap_model_inst (.i_ref_clk(clk), .i_reset_input_n(rin_n),
    .i_cfg(4'hD), .o_pins(pins));
  chip_select_byte_lane_decode chip_select_byte_lane_decode_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_bus_clk(bus_clk), .i_reset_input_n(rin_n),
    .i_boot_strap_pins(pins), .i_boot_window_valid_bit(vbit), .i_win_valid(8'h0F),
    .i_win_base(base), .i_win_mask(mask), .i_win_port_width(16'h00A4),
    .i_win_read_burst(rburst), .i_win_write_burst(wburst), .i_win_wait_states(waits),
    .i_win_internal_ack_enable(iack), .i_win_lane_mode_bit(8'hFD),
    .i_cycle_valid(cvalid), .i_cycle_addr(addr), .i_cycle_size(size), .i_cycle_read(rd),
    .o_boot_window_select_n(cs0_n), .o_chip_select_n(cs_n), .o_output_strobe_n(oe_n),
    .o_lane_select_n(lanes_n), .o_port_width(pw), .o_wait_states(wst),
    .o_internal_ack_enable(iak), .o_burst_inhibit(binh), .o_multi_match(multi),
    .o_cycle_ack(ack), .o_boot_global(bglob));
  // Reference clock and slower bus clock
  initial forever #25 clk = ~clk;
  initial forever begin
    repeat (4) @(posedge clk);
    #5 bus_clk = ~bus_clk;
  end
  // Timeout and ack pulse count
  always @(posedge clk) begin
    cyc_cnt = cyc_cnt + 1;
    if (ack === 1'b1) acks = acks + 1;
    if (cyc_cnt == 8000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  // Compare and count
  task check(input [12:0] seen, input [12:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Lane pattern by size, low address and port width
  function [3:0] lanes(input [1:0] s, input [1:0] a, input [1:0] w);
    begin
      if (w == 2'h1) lanes = 4'hE;
      else if (w[1]) lanes = (s != 2'h1) ? 4'hC : (a[0] ? 4'hD : 4'hE);
      else if (s == 2'h1) lanes = ~(4'h1 << a);
      else if (s == 2'h2) lanes = a[1] ? 4'h3 : 4'hC;
      else lanes = 4'h0;
    end
  endfunction
  // Expected pins for a cycle in a region
  function [12:0] expect_of(input [2:0] rg, input [1:0] s, input [1:0] a, input r);
    reg [7:0] sel;
    reg [1:0] w;
    reg m;
    begin
      w = 2'h0;
      m = 1'b1;
      sel = 8'hFF;
      case (rg)
        3'h0: sel = 8'hFE;
        3'h1: begin
          sel = 8'hFD;
          w = 2'h1;
          m = 1'b0;
        end
        3'h2: begin
          sel = 8'hF7;
          w = 2'h2;
        end
        3'h3: sel = 8'hF3;
        default: sel = 8'hFF;
      endcase
      if (!vbit) begin
        sel = 8'hFE;
        w = 2'h2;
        m = 1'b1; // Strap lane mode: byte enables
      end
      expect_of = {sel, ~(r && sel != 8'hFF), (m || !r) ? lanes(s, a, w) : 4'hF};
    end
  endfunction
  // One bus cycle held for n falls, then one idle fall
  task bus(input [31:0] a, input [1:0] s, input r, input [12:0] e, input integer n);
    begin
      @(posedge bus_clk);
      cvalid = 1'b1;
      addr = a;
      size = s;
      rd = r;
      repeat (n) begin
        exq.push_back(e);
        @(posedge bus_clk);
      end
      cvalid = 1'b0;
      exq.push_back(13'h1FFF);
    end
  endtask
  // Random cycles over all regions and sizes
  task rnd(input integer n);
    reg [2:0] rg;
    reg [1:0] s, a;
    reg r;
    begin
      repeat (n) begin
        rg = $urandom % 5;
        s = $urandom;
        a = $urandom;
        r = $urandom;
        if (s == 2'h2) a[0] = 1'b0;
        if (s == 2'h0 || s == 2'h3) a = 2'h0;
        bus({HI_TAB[rg*16+:16], 14'($urandom), a}, s, r, expect_of(rg, s, a, r), 1);
      end
    end
  endtask
  // Pop the oldest note after each fall has landed
  initial forever begin
    @(negedge bus_clk);
    repeat (4) @(posedge clk);
    #1;
    if (exq.size() > 0) check({cs_n, cs0_n, oe_n, lanes_n}, exq.pop_front());
  end
  // Main sequence
  initial begin
    i = $urandom(32'h93BBBFDC);
    rburst = $urandom;
    wburst = $urandom;
    iack = $urandom;
    waits = $urandom;
    repeat (16) @(posedge clk);
    #5 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #5 rin_n = 1'b1;
    repeat (20) @(posedge clk);
    // Boot read held until the internal ack
    bus(32'h01000001, 2'h1, 1'b1, expect_of(3'h4, 2'h1, 2'h1, 1'b1), 18);
    check(acks[12:0], 13'h1);
    check({12'h0, bglob}, 13'h1);
    rnd(10);
    vbit = 1'b1;
    rnd(60);
    // Window 1 write with internal ack and three waits: ack on fifth fall
    iack[1] = 1'b1;
    waits[7:4] = 4'h3;
    i = acks;
    bus(32'h00010000, 2'h1, 1'b0, expect_of(3'h1, 2'h1, 2'h0, 1'b0), 4);
    @(posedge bus_clk);
    check(acks[12:0], i[12:0]);
    bus(32'h00010000, 2'h1, 1'b0, expect_of(3'h1, 2'h1, 2'h0, 1'b0), 5);
    check(acks[12:0], i[12:0] + 13'h1);
    check({4'h0, pw, wst, iak, binh, multi}, {4'h0, 2'h1, 4'h3, 1'b1, ~wburst[1], 1'b0});
    @(posedge bus_clk);
    check(exq.size(), 13'h0);
    check({12'h0, bglob}, 13'h0);
    final_report;
  end
endmodule
